// ===== design/mic_pkg.sv
// mic_pkg: constants for the interrupt controller block
// assumes a single 100 MHz clock domain and an axi4-lite register bus
package mic_pkg;
    // register byte offsets
    localparam logic [7:0] MIC_OFS_CTRL = 8'h00;   // nmi edge, sense, line enables
    localparam logic [7:0] MIC_OFS_ENA = 8'h04;    // internal source enables
    localparam logic [7:0] MIC_OFS_STAT = 8'h08;   // pending status, read only
    localparam logic [7:0] MIC_OFS_VECT = 8'h0c;   // current vector, read only
    // field positions in the control register
    localparam int MIC_BIT_NMIEDGE = 0;
    localparam int MIC_LSB_SENSE = 4;
    localparam int MIC_LSB_LINEEN = 8;
    // reset values
    localparam logic MIC_RST_NMIEDGE = 1'b0;       // falling edge
    localparam logic [2:0] MIC_RST_SENSE = 3'h0;   // low level
    localparam logic [2:0] MIC_RST_LINEEN = 3'h0;  // lines disabled
    // vector numbers
    localparam logic [5:0] MIC_VEC_NMI = 6'h03;
    localparam logic [5:0] MIC_VEC_EXT0 = 6'h04;
    localparam logic [5:0] MIC_VEC_NONE = 6'h00;
    // internal request count and their vector numbers, 12..35 skipping reserved
    localparam int MIC_NUM_INT = 18;
    localparam logic [5:0] MIC_VEC_INT [MIC_NUM_INT] = '{
        6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12, 6'h13, 6'h14,
        6'h15, 6'h16, 6'h17, 6'h18, 6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h23};
    // arbitration latency in clock states
    localparam int MIC_ARB_EXT = 2;
    localparam int MIC_ARB_INT = 1;
    // axi responses
    localparam logic [1:0] MIC_RESP_OKAY = 2'h0;
    localparam logic [1:0] MIC_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {MIC_ARB_IDLE, MIC_ARB_WAIT, MIC_ARB_OFFER} mic_arb_t;
endpackage

// ===== design/mic_line_detect.sv
// mic_line_detect: synchroniser and edge detector for one request pin
// assumes pin may change at any time relative to clk
`timescale 1ns/10ps
module mic_line_detect (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic pinIn,
    output logic level,
    output logic fallPulse,
    output logic risePulse
);
    logic meta_reg; // first stage, read only by sync_reg
    logic sync_reg; // second stage
    logic prev_reg; // previous synchronised level

    // two-stage synchroniser, idle high
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            meta_reg <= pinIn;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign fallPulse = prev_reg & ~sync_reg;
    assign risePulse = ~prev_reg & sync_reg;
endmodule // mic_line_detect

// ===== design/mic_interrupt_controller.sv
// mic_interrupt_controller: request collection, masking and fixed-priority arbitration
// assumes the cpu core takes the vector with irqAck and drives the mask bit
//
// Summary of operation
// - nmi on selected edge, ignores mask
// - nmi vector number is 3
// - nmi sequence forces mask bit to one
// - ext lines low level or falling edge
// - ext lines gated by mask and enables
// - ext lines vectors 4-6, line 0 highest
// - detection independent of pin direction
// - eighteen internal requests, vectors 12-35
// - internal masked; accept sets mask bit
// - disabled source reaches arbiter only as an already latched ext edge
// - nmi accepted except reset or standby
// - masked requests stay pending, not lost
// - highest priority passed, others stay pending
// - arbitration two states ext, one internal
// - clears act after the clearing instruction
// - word accesses force address bit 0 low
// - nmi edge select 0 falling, 1 rising
// - sense 0 low level, 1 falling edge
// - latched edge cleared when masked, disabled and sense set to level
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
module mic_interrupt_controller
    import mic_pkg::*;
#(
    parameter int NUM_INT = MIC_NUM_INT
) (
    input wire logic clk,
    input wire logic arst_n,
    // pins and core handshake
    input wire logic nmiPin,
    input wire logic [2:0] extRequestPin_n,
    input wire logic [NUM_INT-1:0] intRequest,
    input wire logic standby,
    input wire logic globalMaskBit,
    input wire logic irqAck,
    input wire logic [15:0] cpuAddr,
    output logic irqReq,
    output logic [5:0] irqVector,
    output logic forceMask,
    output logic [15:0] wordAddr,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // control registers
    logic nmiEdgeSelect_reg; // 0 falling, 1 rising
    logic [2:0] irqSenseSelect_reg; // per line: 0 level, 1 edge
    logic [2:0] irqLineEnable_reg; // per line enable
    logic [NUM_INT-1:0] intEnable_reg; // internal source enables
    // pending state
    logic nmiPending_reg;
    logic [2:0] extEdge_reg; // latched falling edges
    // synchronised pins
    logic [2:0] extLevel;
    logic [2:0] extFall;
    logic nmiFall;
    logic nmiRise;
    // arbitration
    mic_arb_t arbState_reg;
    logic [5:0] cand;
    logic candIsExt;
    logic candValid;
    logic candNmi;
    logic [2:0] extReq;
    logic [NUM_INT-1:0] intReq;
    // bus
    logic awHeld_reg;
    logic wHeld_reg;
    logic [7:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic doWrite;

    // nmi pin and external lines through synchronisers; direction-independent
    mic_line_detect uNmi (
        .clk(clk),
        .arst_n(arst_n),
        .pinIn(nmiPin),
        .level(),
        .fallPulse(nmiFall),
        .risePulse(nmiRise)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : gLine
            // each line synchronised then sensed; pin direction not consulted
            mic_line_detect uExt (
                .clk(clk),
                .arst_n(arst_n),
                .pinIn(extRequestPin_n[gi]),
                .level(extLevel[gi]),
                .fallPulse(extFall[gi]),
                .risePulse()
            );
        end
    endgenerate

    // nmi pending latch: selected edge sets, acceptance clears, set wins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nmiPending_reg <= 1'b0;
        end else if (standby) begin
            nmiPending_reg <= 1'b0;
        end else if (nmiEdgeSelect_reg ? nmiRise : nmiFall) begin
            nmiPending_reg <= 1'b1;
        end else if (irqAck && arbState_reg == MIC_ARB_OFFER && irqVector == MIC_VEC_NMI) begin
            nmiPending_reg <= 1'b0;
        end
    end

    // external edge latches: only while enabled; cleared on accept or by clear recipe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            extEdge_reg <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (extFall[i] && irqLineEnable_reg[i]) begin
                    extEdge_reg[i] <= 1'b1;
                end else if (irqAck && arbState_reg == MIC_ARB_OFFER
                             && irqVector == MIC_VEC_EXT0 + 6'(i)) begin
                    extEdge_reg[i] <= 1'b0;
                end else if (globalMaskBit && !irqSenseSelect_reg[i]
                             && !irqLineEnable_reg[i]) begin
                    extEdge_reg[i] <= 1'b0;
                end
            end
        end
    end

    // requests reaching arbiter: level needs enable; latched edge stays pending
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            extReq[i] = irqSenseSelect_reg[i] ? extEdge_reg[i]
                        : (!extLevel[i] && irqLineEnable_reg[i]);
        end
        intReq = intRequest & intEnable_reg;
    end

    // fixed priority: nmi, ext 0..2, internal by vector order; mask gates maskables
    always_comb begin
        cand = MIC_VEC_NONE;
        candIsExt = 1'b0;
        candValid = 1'b0;
        candNmi = 1'b0;
        if (nmiPending_reg) begin
            cand = MIC_VEC_NMI;
            candValid = 1'b1;
            candNmi = 1'b1;
        end else if (!globalMaskBit) begin
            for (int i = NUM_INT - 1; i >= 0; i--) begin
                if (intReq[i]) begin
                    cand = MIC_VEC_INT[i];
                    candValid = 1'b1;
                end
            end
            for (int i = 2; i >= 0; i--) begin
                if (extReq[i]) begin
                    cand = MIC_VEC_EXT0 + 6'(i);
                    candValid = 1'b1;
                    candIsExt = 1'b1;
                end
            end
        end
    end

    // arbiter: ext requests take an extra wait state before offering
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            arbState_reg <= MIC_ARB_IDLE;
            irqReq <= 1'b0;
            irqVector <= MIC_VEC_NONE;
            forceMask <= 1'b0;
        end else begin
            case (arbState_reg)
                MIC_ARB_IDLE: begin
                    irqReq <= 1'b0;
                    forceMask <= 1'b0;
                    // while the mask bit is being set only the nmi may start
                    if (candValid && !standby && (candNmi || !forceMask)) begin
                        if (candIsExt || candNmi) begin
                            arbState_reg <= MIC_ARB_WAIT;
                        end else begin
                            arbState_reg <= MIC_ARB_OFFER;
                            irqReq <= 1'b1;
                            irqVector <= cand;
                        end
                    end
                end
                MIC_ARB_WAIT: begin
                    // re-evaluate: a cleared enable drops the offer after its instruction
                    if (candValid && !standby) begin
                        arbState_reg <= MIC_ARB_OFFER;
                        irqReq <= 1'b1;
                        irqVector <= cand;
                    end else begin
                        arbState_reg <= MIC_ARB_IDLE;
                    end
                end
                MIC_ARB_OFFER: begin
                    if (irqAck) begin
                        // accepted: cpu sets mask; request line drops
                        arbState_reg <= MIC_ARB_IDLE;
                        irqReq <= 1'b0;
                        forceMask <= 1'b1;
                    end else if (!candValid || standby) begin
                        arbState_reg <= MIC_ARB_IDLE;
                        irqReq <= 1'b0;
                    end else begin
                        irqVector <= cand;
                    end
                end
                default: begin
                    arbState_reg <= MIC_ARB_IDLE;
                    irqReq <= 1'b0;
                end
            endcase
        end
    end

    // word address with bit 0 forced low for stack and word accesses
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wordAddr <= 16'h0000;
        end else begin
            wordAddr <= {cpuAddr[15:1], 1'b0};
        end
    end

    // axi write channel capture, address and data in either order
    assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= 8'h00;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= MIC_RESP_OKAY;
        end else begin
            s_axi_awready <= !awHeld_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !wHeld_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr_reg == MIC_OFS_CTRL || awAddr_reg == MIC_OFS_ENA)
                               ? MIC_RESP_OKAY : MIC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control register writes; ctrl honours strobe lanes 0 and 1, ena ignores strobes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nmiEdgeSelect_reg <= MIC_RST_NMIEDGE;
            irqSenseSelect_reg <= MIC_RST_SENSE;
            irqLineEnable_reg <= MIC_RST_LINEEN;
            intEnable_reg <= '0;
        end else if (doWrite) begin
            if (awAddr_reg == MIC_OFS_CTRL) begin
                if (wStrb_reg[0]) begin
                    nmiEdgeSelect_reg <= wData_reg[MIC_BIT_NMIEDGE];
                    irqSenseSelect_reg <= wData_reg[MIC_LSB_SENSE +: 3];
                end
                if (wStrb_reg[1]) begin
                    irqLineEnable_reg <= wData_reg[MIC_LSB_LINEEN +: 3];
                end
            end else if (awAddr_reg == MIC_OFS_ENA) begin
                intEnable_reg <= wData_reg[NUM_INT-1:0];
            end
        end
    end

    // axi read channel, one cycle address accept then data
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= MIC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= MIC_RESP_OKAY;
                case (s_axi_araddr)
                    MIC_OFS_CTRL: s_axi_rdata <= 32'({irqLineEnable_reg, 1'b0,
                        irqSenseSelect_reg, 3'h0, nmiEdgeSelect_reg});
                    MIC_OFS_ENA: s_axi_rdata <= 32'(intEnable_reg);
                    MIC_OFS_STAT: s_axi_rdata <= 32'({intReq, extReq, nmiPending_reg});
                    MIC_OFS_VECT: s_axi_rdata <= 32'({irqReq, irqVector});
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= MIC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // mic_interrupt_controller

// ===== test/mic_interrupt_controller_properties.sv
// checker: port relations of the interrupt controller
// assumes it is bound into mic_interrupt_controller
`timescale 1ns/10ps
module mic_interrupt_controller_properties
    import mic_pkg::*;
#(
    parameter int NUM_INT = MIC_NUM_INT
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [NUM_INT-1:0] intRequest,
    input wire logic standby,
    input wire logic globalMaskBit,
    input wire logic irqAck,
    input wire logic [15:0] cpuAddr,
    input wire logic irqReq,
    input wire logic [5:0] irqVector,
    input wire logic forceMask,
    input wire logic [15:0] wordAddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // only nmi, line and peripheral vectors are offered
    chk_vec_range:
    assert property (irqReq |-> irqVector inside {[3:6], [12:35]})
        else $error("offered vector out of range");
    // an accepted offer is withdrawn and the mask forced
    chk_ack_drops:
    assert property (irqReq && irqAck |=> !irqReq && forceMask)
        else $error("offer kept or no mask after accept");
    // mask forcing only follows an accept
    chk_force_cause:
    assert property (forceMask |-> $past(irqAck) && $past(irqReq))
        else $error("mask forced without accept");
    // no maskable offer while the mask bit is being set
    chk_entry_quiet:
    assert property (forceMask |=> !irqReq)
        else $error("offer made while mask being set");
    // a steady mask lets only the nmi through
    chk_mask_blocks:
    assert property (globalMaskBit [*3] ##0 irqReq |-> irqVector == MIC_VEC_NMI)
        else $error("maskable request offered while masked");
    // standby offers nothing
    chk_standby_quiet:
    assert property (standby [*3] |-> !irqReq)
        else $error("offer during standby");
    // word address always even, one cycle late
    chk_word_align:
    assert property (1'b1 |=> wordAddr == ($past(cpuAddr) & 16'hfffe))
        else $error("word address not aligned copy");
    // read data follows the address handshake
    chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    // write response leaves after it is taken
    chk_write_done:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response stuck");
    cover property (irqAck && irqVector == MIC_VEC_NMI);
    cover property (irqAck && irqVector == MIC_VEC_EXT0);
    cover property (irqAck && intRequest[NUM_INT-1]);
endmodule // mic_interrupt_controller_properties

// ===== test/mic_cpu_model.sv
// mic_cpu_model: behavioural cpu exception sequencer
// assumes the bench pulses excReturn to return and may hold the mask
`timescale 1ns/10ps
module mic_cpu_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic irqReq,
    input wire logic [5:0] irqVector,
    input wire logic forceMask,
    input wire logic excReturn,
    input wire logic holdMask,
    input wire logic [2:0] instrLen,
    output logic irqAck,
    output logic globalMaskBit,
    output logic [15:0] cpuAddr
);
    logic maskReg; // i bit of the flag byte
    logic [2:0] waitReg; // states left in the current instruction
    logic [5:0] vecReg; // latched vector number
    logic [15:0] stackReg; // stack pointer, odd on purpose
    assign globalMaskBit = maskReg | holdMask;
    // accept only at an instruction boundary
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irqAck <= 1'b0;
            waitReg <= 3'h0;
        end else begin
            irqAck <= 1'b0;
            if (!irqReq || irqAck) waitReg <= instrLen;
            else if (waitReg != 3'h0) waitReg <= waitReg - 3'h1;
            else irqAck <= 1'b1;
        end
    end
    // mask set on entry, cleared by return
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) maskReg <= 1'b0;
        else if (forceMask) maskReg <= 1'b1;
        else if (excReturn) maskReg <= 1'b0;
    end
    // push pc and flags, then fetch the vector entry
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stackReg <= 16'hfeff;
            vecReg <= 6'h0;
            cpuAddr <= 16'h0;
        end else if (irqAck) begin
            vecReg <= irqVector;
            cpuAddr <= stackReg;
            stackReg <= stackReg - 16'h4;
        end else begin
            cpuAddr <= {9'h0, vecReg, 1'b1};
        end
    end
endmodule // mic_cpu_model

// ===== test/tb.sv
// tb: controller, cpu model and axi4-lite register tests
// assumes checker and model are compiled first
`timescale 1ns/10ps
module tb import mic_pkg::*; ;
    logic clk = 1'b0, arst_n = 1'b0, nmiPin = 1'b1, standby = 1'b0;
    logic excReturn = 1'b0, holdMask = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0;
    logic arv = 1'b0, rready = 1'b0, irqAck, maskBit, irqReq, forceMask;
    logic [2:0] extPin_n = 3'h7, instrLen = 3'h2;
    logic [17:0] intReq = 18'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [15:0] cpuAddr, wordAddr;
    logic [5:0] irqVector;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid;
    int fails = 0, total_checks = 0, cycles = 0;
    mic_interrupt_controller i_mic_interrupt_controller (
        .clk(clk), .arst_n(arst_n), .nmiPin(nmiPin), .extRequestPin_n(extPin_n),
        .intRequest(intReq), .standby(standby), .globalMaskBit(maskBit),
        .irqAck(irqAck), .cpuAddr(cpuAddr), .irqReq(irqReq), .irqVector(irqVector),
        .forceMask(forceMask), .wordAddr(wordAddr), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    mic_cpu_model i_mic_cpu_model (
        .clk(clk), .arst_n(arst_n), .irqReq(irqReq), .irqVector(irqVector),
        .forceMask(forceMask), .excReturn(excReturn), .holdMask(holdMask), .instrLen(instrLen),
        .irqAck(irqAck), .globalMaskBit(maskBit), .cpuAddr(cpuAddr));
    always #5 clk = ~clk;
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // axi write, both channels offered together
    task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awv <= 1'b0;
            if (wready === 1'b1) wv <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        check(32'(bresp), 32'(r));
    endtask
    // axi read with data and response compare
    task automatic axiRd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arv <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        check(rdata, d);
        check(32'(rresp), 32'(r));
    endtask
    // wait for the cpu to accept, compare the vector
    task automatic expectAck(input logic [5:0] v, input logic want);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (irqAck !== 1'b1 && n < 40);
        check(32'(irqAck === 1'b1), 32'(want));
        if (want) check(32'(irqVector), 32'(v));
    endtask
    // return from the handler
    task automatic retn();
        repeat (4) @(posedge clk);
        excReturn <= 1'b1;
        @(posedge clk);
        excReturn <= 1'b0;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        axiRd(MIC_OFS_CTRL, 32'h0, MIC_RESP_OKAY);
        axiRd(MIC_OFS_ENA, 32'h0, MIC_RESP_OKAY);
        axiRd(8'h10, 32'h0, MIC_RESP_SLVERR);
        axiWr(8'h14, 32'h1, MIC_RESP_SLVERR);
        $display("registers done");
        axiWr(MIC_OFS_ENA, 32'h3ffff, MIC_RESP_OKAY);
        for (int i = 0; i < MIC_NUM_INT; i++) begin
            intReq[i] <= 1'b1;
            expectAck(MIC_VEC_INT[i], 1'b1);
            intReq[i] <= 1'b0;
            retn();
        end
        holdMask <= 1'b1;
        intReq <= 18'h20001;
        expectAck(6'h0, 1'b0);
        axiRd(MIC_OFS_STAT, 32'h0020_0010, MIC_RESP_OKAY);
        holdMask <= 1'b0;
        expectAck(MIC_VEC_INT[0], 1'b1);
        intReq[0] <= 1'b0;
        retn();
        expectAck(MIC_VEC_INT[17], 1'b1);
        intReq <= 18'h0;
        retn();
        axiWr(MIC_OFS_ENA, 32'h3fffe, MIC_RESP_OKAY);
        intReq[0] <= 1'b1;
        expectAck(6'h0, 1'b0);
        intReq[0] <= 1'b0;
        $display("internal requests done");
        axiWr(MIC_OFS_CTRL, 32'h700, MIC_RESP_OKAY);
        holdMask <= 1'b1;
        extPin_n <= 3'h0;
        repeat (6) @(posedge clk);
        holdMask <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            expectAck(MIC_VEC_EXT0 + 6'(k), 1'b1);
            extPin_n[k] <= 1'b1;
            retn();
        end
        axiWr(MIC_OFS_CTRL, 32'h770, MIC_RESP_OKAY);
        holdMask <= 1'b1;
        extPin_n[1] <= 1'b0;
        repeat (3) @(posedge clk);
        extPin_n[1] <= 1'b1;
        repeat (6) @(posedge clk);
        holdMask <= 1'b0;
        expectAck(MIC_VEC_EXT0 + 6'h1, 1'b1);
        retn();
        holdMask <= 1'b1;
        extPin_n[2] <= 1'b0;
        repeat (3) @(posedge clk);
        extPin_n[2] <= 1'b1;
        axiWr(MIC_OFS_CTRL, 32'h0, MIC_RESP_OKAY);
        axiWr(MIC_OFS_CTRL, 32'h770, MIC_RESP_OKAY);
        holdMask <= 1'b0;
        expectAck(6'h0, 1'b0);
        axiWr(MIC_OFS_CTRL, 32'h600, MIC_RESP_OKAY);
        extPin_n[0] <= 1'b0;
        expectAck(6'h0, 1'b0);
        extPin_n[0] <= 1'b1;
        $display("external lines done");
        holdMask <= 1'b1;
        for (int e = 0; e < 4; e++) begin
            if (e == 2) axiWr(MIC_OFS_CTRL, 32'h1, MIC_RESP_OKAY);
            nmiPin <= ~nmiPin;
            expectAck(MIC_VEC_NMI, 1'(e == 0 || e == 3));
        end
        standby <= 1'b1;
        nmiPin <= 1'b0;
        repeat (4) @(posedge clk);
        nmiPin <= 1'b1;
        expectAck(6'h0, 1'b0);
        standby <= 1'b0;
        expectAck(6'h0, 1'b0);
        holdMask <= 1'b0;
        retn();
        $display("nmi done");
        test_done();
    end
endmodule // tb
bind mic_interrupt_controller mic_interrupt_controller_properties #(.NUM_INT(NUM_INT))
    i_mic_interrupt_controller_properties (.clk, .arst_n, .intRequest, .standby,
    .globalMaskBit, .irqAck, .cpuAddr, .irqReq, .irqVector, .forceMask, .wordAddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready);
